//--- flic_pkg.sv
package flic_pkg;
   localparam int NSRC = 7;
   localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'ha8;
   localparam logic [7:0] ADDR_PRIO_UPPER  = 8'hb7;
   localparam logic [7:0] ADDR_PRIO_LOWER  = 8'hb8;
   localparam logic [7:0] ADDR_EVT_STATUS  = 8'hc0;
   localparam logic [7:0] ADDR_EVT_CLEAR   = 8'hc1;
   localparam logic [7:0] ADDR_EVT_ENABLE  = 8'hc2;
   localparam logic [7:0] ADDR_CORE_STATUS = 8'hc3;
   localparam logic [7:0] ADDR_BIT_WRITE   = 8'hc4;
   localparam int GLOBAL_GATE_BIT = 7;
   localparam logic [7:0] RESET_IRQ_ENABLE = 8'h00;
   localparam logic [6:0] RESET_PRIO       = 7'h00;
   localparam logic [1:0] RESET_EVT        = 2'h0;
   // source indices in polling order; index equals register bit
   localparam int SRC_EXT0    = 0;
   localparam int SRC_TIMER0  = 1;
   localparam int SRC_EXT1    = 2;
   localparam int SRC_TIMER1  = 3;
   localparam int SRC_SERIAL  = 4;
   localparam int SRC_TIMER2  = 5;
   localparam int SRC_CNT_ARR = 6;
   // event bits of the block's own interrupt status
   localparam int EVT_GRANT   = 0;
   localparam int EVT_PREEMPT = 1;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } flic_bus_req_t;

   typedef struct packed {
      logic       valid;
      logic [2:0] src;
      logic [1:0] level;
   } flic_grant_t;
endpackage : flic_pkg

//--- flic_arbiter.sv
`timescale 1ns/1ps
module flic_arbiter
   import flic_pkg::*;
(
   input  wire  logic [NSRC-1:0] req,
   input  wire  logic [NSRC-1:0] lvl_hi,
   input  wire  logic [NSRC-1:0] lvl_lo,
   output flic_pkg::flic_grant_t grant
);
   import flic_pkg::*;

   logic [1:0] lvl [NSRC];

   genvar g;
   generate
      for (g = 0; g < NSRC; g++)
      begin : g_lvl
         assign lvl[g] = {lvl_hi[g], lvl_lo[g]};
      end
   endgenerate

   always_comb
   begin
      grant = '0;
      for (int i = 0; i < NSRC; i++)
      begin
         // strict greater keeps earliest polled source on ties
         if (req[i] && (!grant.valid || lvl[i] > grant.level))
         begin
            grant.valid = 1'b1;
            grant.src   = 3'(i);
            grant.level = lvl[i];
         end
      end
   end
endmodule : flic_arbiter

//--- flic_controller.sv
`timescale 1ns/1ps
// Functional notes
// - seven request inputs: two pins, three timers, serial, counter array
// - each source forwarded only while its own enable bit is set
// - enable bit 7 gates all; clear means no interrupt taken
// - enable bits: 6 counter array, 5 timer2, 4 serial ... 0 ext0
// - enable register resets to zero and supports single-bit writes
// - level = {high bit, low bit}; 0 lowest, 3 highest
// - low priority register uses enable layout, bit 7 reserved
// - high priority register uses same layout, bit 7 reserved
// - both priority registers reset to zero; only low one bit-writable
// - only a strictly higher level preempts; level 3 never preempted
// - between different pending levels the higher level is granted
// - same-level ties resolved by fixed polling order
module flic_controller
(
   input  wire  logic                  clk,
   input  wire  logic                  srst,
   input  wire  logic [7:0]            addr,
   input  wire  logic [7:0]            wdata,
   input  wire  logic                  wr,
   input  wire  logic                  rd,
   output       logic [7:0]            rdata,
   input  wire  logic                  ext_request_zero,
   input  wire  logic                  ext_request_one,
   input  wire  logic                  timer0_ovf,
   input  wire  logic                  timer1_ovf,
   input  wire  logic                  timer2_ovf,
   input  wire  logic                  serial_req,
   input  wire  logic                  counter_array_req,
   output       logic                  core_irq,
   output       logic [2:0]            core_irq_src,
   output       logic [1:0]            core_irq_level,
   input  wire  logic                  core_ack,
   input  wire  logic                  core_reti,
   output       logic                  evt_irq
);
   import flic_pkg::*;

   typedef struct packed {
      logic [1:0] pin0_sync;
      logic [1:0] pin1_sync;
      logic [7:0] irq_enable_reg;
      logic [6:0] prio_upper_bits_reg;
      logic [6:0] prio_lower_bits_reg;
      logic [3:0] active;
      logic [1:0] evt_status;
      logic [1:0] evt_enable;
      logic [7:0] rdata;
      logic       irq;
      logic [2:0] irq_src;
      logic [1:0] irq_level;
   } flic_state_t;

   flic_state_t   r;
   flic_state_t   next_r;
   flic_bus_req_t bus;
   flic_grant_t   grant;
   logic [NSRC-1:0] src_req;
   logic [NSRC-1:0] gated_req;
   logic [2:0]    top_active;
   logic          any_active;
   logic [3:0]    held;
   logic [2:0]    top_held;
   logic          take;

   assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   // pins synchronised, on-chip sources used as is
   assign src_req[SRC_EXT0]    = r.pin0_sync[1];
   assign src_req[SRC_TIMER0]  = timer0_ovf;
   assign src_req[SRC_EXT1]    = r.pin1_sync[1];
   assign src_req[SRC_TIMER1]  = timer1_ovf;
   assign src_req[SRC_SERIAL]  = serial_req;
   assign src_req[SRC_TIMER2]  = timer2_ovf;
   assign src_req[SRC_CNT_ARR] = counter_array_req;

   assign gated_req = src_req & r.irq_enable_reg[NSRC-1:0]
                      & {NSRC{r.irq_enable_reg[GLOBAL_GATE_BIT]}};

   flic_arbiter u_arb
   (
      .req    (gated_req),
      .lvl_hi (r.prio_upper_bits_reg),
      .lvl_lo (r.prio_lower_bits_reg),
      .grant  (grant)
   );

   // highest level currently in service
   always_comb
   begin
      top_active = 3'h0;
      for (int l = 0; l < 4; l++)
      begin
         if (r.active[l])
         begin
            top_active = 3'(l);
         end
      end
   end

   assign any_active = |r.active;

   // service levels as they stand after this edge's ack and reti
   always_comb
   begin
      held = r.active;
      if (core_reti && any_active)
      begin
         held[top_active[1:0]] = 1'b0;
      end
      if (core_ack && r.irq)
      begin
         held[r.irq_level] = 1'b1;
      end
   end

   always_comb
   begin
      top_held = 3'h0;
      for (int l = 0; l < 4; l++)
      begin
         if (held[l])
         begin
            top_held = 3'(l);
         end
      end
   end

   // strictly higher level only; level 3 cannot be exceeded
   // judged against the level just entered, so an acked request drops at once
   assign take = grant.valid && (!(|held) || 3'(grant.level) > top_held);

   always_comb
   begin
      next_r = r;
      next_r.pin0_sync = {r.pin0_sync[0], ext_request_zero};
      next_r.pin1_sync = {r.pin1_sync[0], ext_request_one};
      next_r.rdata = 8'h00;
      next_r.irq       = take;
      next_r.irq_src   = grant.src;
      next_r.irq_level = grant.level;

      if (bus.wr)
      begin
         unique case (bus.addr)
            ADDR_IRQ_ENABLE: next_r.irq_enable_reg = bus.wdata;
            ADDR_PRIO_UPPER: next_r.prio_upper_bits_reg = bus.wdata[6:0];
            ADDR_PRIO_LOWER: next_r.prio_lower_bits_reg = bus.wdata[6:0];
            ADDR_EVT_ENABLE: next_r.evt_enable = bus.wdata[1:0];
            ADDR_EVT_CLEAR:  next_r.evt_status = r.evt_status & ~bus.wdata[1:0];
            // bit write: data[7] value, data[3] sel low prio, data[2:0] bit
            ADDR_BIT_WRITE:
            begin
               if (bus.wdata[3])
               begin
                  if (bus.wdata[2:0] != 3'h7)
                  begin
                     next_r.prio_lower_bits_reg[bus.wdata[2:0]] = bus.wdata[7];
                  end
               end
               else
               begin
                  next_r.irq_enable_reg[bus.wdata[2:0]] = bus.wdata[7];
               end
            end
            default: ;
         endcase
      end

      if (bus.rd)
      begin
         unique case (bus.addr)
            ADDR_IRQ_ENABLE:  next_r.rdata = r.irq_enable_reg;
            ADDR_PRIO_UPPER:  next_r.rdata = {1'b0, r.prio_upper_bits_reg};
            ADDR_PRIO_LOWER:  next_r.rdata = {1'b0, r.prio_lower_bits_reg};
            ADDR_EVT_STATUS:  next_r.rdata = {6'h00, r.evt_status};
            ADDR_EVT_ENABLE:  next_r.rdata = {6'h00, r.evt_enable};
            ADDR_CORE_STATUS: next_r.rdata = {4'h0, r.active};
            default:          next_r.rdata = 8'h00;
         endcase
      end

      // nesting stack: reti retires highest, ack enters granted level
      next_r.active = held;
      if (core_ack && r.irq)
      begin
         next_r.evt_status[EVT_GRANT] = 1'b1;
         if (any_active)
         begin
            next_r.evt_status[EVT_PREEMPT] = 1'b1;
         end
      end

      if (srst)
      begin
         next_r = '0;
         next_r.irq_enable_reg      = RESET_IRQ_ENABLE;
         next_r.prio_upper_bits_reg = RESET_PRIO;
         next_r.prio_lower_bits_reg = RESET_PRIO;
         next_r.evt_status          = RESET_EVT;
         next_r.evt_enable          = RESET_EVT;
      end
   end

   always_ff @(posedge clk)
   begin
      r <= next_r;
   end

   assign rdata          = r.rdata;
   assign core_irq       = r.irq;
   assign core_irq_src   = r.irq_src;
   assign core_irq_level = r.irq_level;
   assign evt_irq        = |(r.evt_status & r.evt_enable);
endmodule : flic_controller

//--- flic_chk.sv
`timescale 1ns/1ps
module flic_chk
(
   input wire logic       clk,
   input wire logic       srst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       core_irq,
   input wire logic [2:0] core_irq_src,
   input wire logic [1:0] core_irq_level,
   input wire logic       core_ack
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   property p_rst; rd && addr == 8'ha8 && $past(srst) |=> rdata == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("enable not clear");
   property p_idle; $fell(srst) |-> !core_irq ##1 !core_irq; endproperty
   a_idle: assert property (p_idle) else $error("irq after reset");
   property p_res; rd && (addr == 8'hb7 || addr == 8'hb8) |=> !rdata[7]; endproperty
   a_res: assert property (p_res) else $error("bit 7 set");
   property p_gate; wr && addr == 8'ha8 && !wdata[7] |-> ##2 !core_irq; endproperty
   a_gate: assert property (p_gate) else $error("gate ignored");
   property p_none; wr && addr == 8'ha8 && wdata[6:0] == 7'h00 |-> ##2 !core_irq; endproperty
   a_none: assert property (p_none) else $error("source not gated");
   property p_nest; core_ack && core_irq |=> !core_irq || core_irq_level > $past(core_irq_level);
   endproperty
   a_nest: assert property (p_nest) else $error("bad preemption");
   property p_top; core_ack && core_irq && core_irq_level == 2'h3 |=> !core_irq; endproperty
   a_top: assert property (p_top) else $error("level 3 preempted");
   property p_src; core_irq |-> core_irq_src < 3'h7; endproperty
   a_src: assert property (p_src) else $error("bad source");
   c_ack: cover property (core_ack && core_irq);
   c_top: cover property (core_irq && core_irq_level == 2'h3);
   c_rd: cover property (rd && addr == 8'hb7);
endmodule : flic_chk
bind flic_controller flic_chk flic_chk_inst (.clk(clk), .srst(srst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .core_irq(core_irq),
   .core_irq_src(core_irq_src), .core_irq_level(core_irq_level), .core_ack(core_ack));

//--- flic_core_model.sv
`timescale 1ns/1ps
module flic_core_model
(
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic core_irq,
   input  wire logic take_en,
   input  wire logic slow,
   output      logic core_ack
);
   logic waited;
   // slow core takes one extra cycle
   always_ff @(posedge clk)
   begin
      waited <= core_irq && slow && !waited && !srst;
      core_ack <= core_irq && take_en && !core_ack && (!slow || waited) && !srst;
   end
endmodule : flic_core_model

//--- flic_controller_bench.sv
`timescale 1ns/1ps
module flic_controller_bench;
   logic       clk = 1'b0;
   logic       srst, wr, rd, take_en, slow, core_reti, core_ack, core_irq, evt_irq;
   logic [7:0] addr, wdata, rdata;
   logic [6:0] src;
   logic [2:0] core_irq_src;
   logic [1:0] core_irq_level;
   int         fail_count, samples_checked, cycles;
   always #25 clk = ~clk;
   flic_controller flic_controller_inst (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .ext_request_zero(src[0]), .timer0_ovf(src[1]),
      .ext_request_one(src[2]), .timer1_ovf(src[3]), .serial_req(src[4]),
      .timer2_ovf(src[5]), .counter_array_req(src[6]), .core_irq(core_irq),
      .core_irq_src(core_irq_src), .core_irq_level(core_irq_level), .core_ack(core_ack),
      .core_reti(core_reti), .evt_irq(evt_irq));
   flic_core_model flic_core_model_inst (.clk(clk), .srst(srst), .core_irq(core_irq),
      .take_en(take_en), .slow(slow), .core_ack(core_ack));
   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      check(rdata, e);
   endtask : rreg
   // expected {evt_irq, core_irq, source, level}
   task automatic irq(input logic [6:0] e);
      repeat (6) @(negedge clk);
      check({1'b0, evt_irq, core_irq, core_irq_src, core_irq_level}, {1'b0, e});
      @(posedge clk);
   endtask : irq
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fail_count++;
         results();
      end
   end
   initial
   begin
      {srst, wr, rd, take_en, slow, core_reti} = 6'b100000;
      {addr, wdata, src} = '0;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      addr <= 8'ha8;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      check(rdata, 8'h00);
      rreg(8'hb7, 8'h00);
      rreg(8'hb8, 8'h00);
      wreg(8'hb8, 8'h7f);
      rreg(8'hb8, 8'h7f);
      wreg(8'hb7, 8'h2a);
      rreg(8'hb7, 8'h2a);
      wreg(8'hb7, 8'h00);
      wreg(8'hb8, 8'h00);
      src <= 7'h02;
      wreg(8'ha8, 8'h80);
      irq(7'h00);
      wreg(8'ha8, 8'h82);
      irq(7'b0_1_001_00);
      wreg(8'ha8, 8'h02);
      irq(7'h00);
      wreg(8'hc4, 8'h87);
      rreg(8'ha8, 8'h82);
      wreg(8'ha8, 8'hff);
      for (int i = 0; i < 7; i++)
      begin
         src <= 7'h7f << i;
         irq({2'b01, i[2:0], 2'b00});
      end
      src <= 7'h7f;
      for (int l = 1; l < 4; l++)
      begin
         wreg(8'hb7, {1'b0, l[1], 6'h00});
         wreg(8'hb8, {1'b0, l[0], 6'h00});
         irq({2'b01, 3'h6, l[1:0]});
      end
      wreg(8'hb7, 8'h00);
      wreg(8'hb8, 8'h40);
      take_en <= 1'b1;
      irq(7'b0_0_110_01);
      take_en <= 1'b0;
      wreg(8'hc2, 8'h03);
      rreg(8'hc0, 8'h01);
      wreg(8'hb8, 8'h41);
      irq(7'b1_0_000_01);
      wreg(8'hb7, 8'h01);
      irq(7'b1_1_000_11);
      slow <= 1'b1;
      take_en <= 1'b1;
      irq(7'b1_0_000_11);
      take_en <= 1'b0;
      rreg(8'hc0, 8'h03);
      wreg(8'hc1, 8'h03);
      core_reti <= 1'b1;
      @(posedge clk);
      core_reti <= 1'b0;
      irq(7'b0_1_000_11);
      results();
   end
endmodule : flic_controller_bench
